// *** dual_timer_asserts.sv ***
// Port checker of the dual timer, bound to the dual_timer_unit module
`timescale 1ns/1ps
module dual_timer_asserts (
    // Clock, reset and register bus
    input wire logic        i_mclk,
    input wire logic        i_rstn,
    input wire logic [7:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // Trigger inputs and timer outputs
    input wire logic        i_meas,
    input wire logic        i_sector_pulse,
    input wire logic        i_step_pulse,
    input wire logic        i_zero_mark,
    input wire logic        i_baud_tick,
    input wire logic [2:0]  i_phase_sync,
    input wire logic        o_event_request,
    input wire logic [1:0]  o_compare_pulse,
    input wire logic        o_pwm
);
    // One domain, so reset masks every check
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    logic req;
    logic ans;
    // Request present, and the cycle it is answered
    assign req = i_avs_read | i_avs_write;
    assign ans = req & !o_avs_waitrequest;
    first_wait_a: assert property (req && !$past(req) |-> o_avs_waitrequest)
        else $error("no first wait");
    wait_one_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("extra wait");
    back_wait_a: assert property (ans |=> !req || o_avs_waitrequest)
        else $error("long answer");
    upper_zero_a: assert property (ans |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper data set");
    read_hold_a: assert property (!req |=> $stable(o_avs_readdata))
        else $error("idle data moved");
    cmp_a_once_a: assert property (o_compare_pulse[0] |=> !o_compare_pulse[0])
        else $error("long compare A");
    cmp_b_once_a: assert property (o_compare_pulse[1] |=> !o_compare_pulse[1])
        else $error("long compare B");
    pwm_clear_a: assert property (o_compare_pulse[1] |=> !o_pwm)
        else $error("pwm not cleared");
    no_pending_a: assert property (ans && i_avs_read && i_avs_address[7:2] == 6'h3E
        && o_avs_readdata[3:0] == 4'h9 |-> !$past(o_event_request))
        else $error("request, none pending");
    // Main scenarios
    cover property (o_compare_pulse[0]);
    cover property (o_compare_pulse[1]);
    cover property (o_event_request);
    cover property (ans && i_avs_write);
endmodule // dual_timer_asserts

bind dual_timer_unit dual_timer_asserts u_chk (.*);

// *** dual_timer_defs.svh ***
// Register indices, field positions, codes and reset values of the dual timer
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

// Register indices (byte address is four times the index)
`define IDX_CLOCK_DIVIDER      6'h00
`define IDX_TIMER_CONTROL      6'h02
`define IDX_UNIT_A_SETUP       6'h04
`define IDX_UNIT_B_SETUP       6'h06
`define IDX_UNIT_A_MATCH       6'h08
`define IDX_UNIT_B_MATCH       6'h0A
`define IDX_UNIT_A_COUNT       6'h0C
`define IDX_UNIT_B_COUNT       6'h0E
`define IDX_UNIT_A_SOURCE      6'h10
`define IDX_UNIT_B_SOURCE      6'h12
`define IDX_EVENT_FLAGS        6'h30
`define IDX_EVENT_GATE         6'h34
`define IDX_VECTOR_SWITCH_ON   6'h38
`define IDX_VECTOR_SWITCH_OFF  6'h3A
`define IDX_NESTING_CEILING    6'h3C
`define IDX_PENDING_VECTOR     6'h3E

// Control register fields
`define CTL_ENABLE_LSB         0
`define CTL_RESTART_A_BIT      2
`define CTL_RESTART_P_BIT      4

// Unit setup fields
`define SETUP_CLK_LSB          0
`define SETUP_RESTART_LSB      2
`define SETUP_CAPTURE_LSB      5
`define SETUP_MODE_LSB         8
`define SETUP_WRITE_MASK       10'h37F

// Source preselect fields
`define PRESEL_CLK_LSB         0
`define PRESEL_RESTART_LSB     4
`define PRESEL_CAPTURE_LSB     8

// Unit modes
`define MODE_COMPARE           2'h0
`define MODE_ONCE              2'h1
`define MODE_LOOP              2'h2
`define MODE_CAPTURE           2'h3

// Restart source codes
`define RST_SRC_ENABLE         3'h0
`define RST_SRC_OTHER_CMP      3'h1
`define RST_SRC_MEAS_RISE      3'h2
`define RST_SRC_MEAS_FALL      3'h3
`define RST_SRC_SYSTEM         3'h4

// Event flag positions
`define FLAG_PRESCALE_RESTART  0
`define FLAG_OVERFLOW_LSB      1
`define FLAG_RESTART_LSB       3
`define FLAG_CAPTURE_LSB       5
`define FLAG_COMPARE_LSB       7
`define FLAG_COUNT             9

// Vector logic values
`define VECTOR_NONE            4'h9
`define CEILING_RESET          4'h9
`define VECTOR_ENABLE_RESET    9'h1FF

// Counter values
`define SIGNED_LIMIT           16'h7FFF
`define COUNT_ZERO             16'h0000

`endif

// *** dual_timer_pkg.sv ***
// Types of the dual capture compare timer
package dual_timer_pkg;

    // Bus answer states, Gray coded
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DONE = 2'b01
    } bus_state_type;

    // Entire state of the timer
    typedef struct packed {
        bus_state_type     bus;
        logic [31:0]       rdata;
        logic [7:0]        pre_val;
        logic [7:0]        pre_cnt;
        logic [1:0]        enable;
        logic [1:0]        enable_prev;
        logic [1:0][9:0]   setup;
        logic [1:0][15:0]  match;
        logic [1:0][15:0]  count;
        logic [1:0]        changed;
        logic [1:0][11:0]  presel;
        logic [8:0]        flags;
        logic [8:0]        gate;
        logic [8:0]        venable;
        logic [3:0]        ceiling;
        logic [2:0]        meas_sync;
        logic [2:0]        phase_prev;
        logic              pwm;
    } state_type;

endpackage

// *** dual_timer_unit.sv ***
// Dual 16-bit capture compare timer with prescaler and Avalon-MM registers
//
// Operation
// - Counter clock tick every prescale setting plus one system clocks.
// - Two independent 16-bit up-counters, unit A and unit B.
// - Control bits 0 and 1 are readable run enables of A and B.
// - Control bits 4, 3, 2 are write-only restarts: prescaler, B, A.
// - Mode 0 compares the counter against the match register.
// - Mode 1 compares and clears its own run enable at the match.
// - Mode 2 compares and restarts the counter at every match.
// - Mode 3 loads the count into the match register on capture.
// - Capture source: other compare, meas rise, meas fall, system signal.
// - Restart source: enable/loop, other compare, rise, fall, system signal.
// - Count source: prescaled clock, meas rise, meas fall, system signal.
// - Each unit has a read-write 16-bit match or snapshot register.
// - Counter registers are read-only, reset to zero, ignore writes.
// - Four-bit preselect codes map to sector, step, zero, baud, phase edges.
// - Preselect bits 7:4 choose the system restart signal.
// - Preselect bits 11:8 choose the system capture signal.
// - Prescaler and counter span up to 256 times 65536 clocks.
// - A captures period or low time while B captures high time.
// - PWM: counter A sets period, match of B sets pulse width.
// - Windowed counting: A windows, B counts edges, threshold raises request.
// - Event flags bits 8..0: cmp B/A, cap B/A, rst B/A, ovf B/A, prescale.
// - Overflow event when the count passes the signed 16-bit limit.
// - Nine-bit gate mask passes each flag onto the interrupt request.
// - Vector read gives lowest enabled pending event; writing it clears it.
`timescale 1ns/1ps

`include "dual_timer_defs.svh"

module dual_timer_unit (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    // Avalon-MM register slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Measurement pin and internal trigger sources
    input  wire logic        i_meas,
    input  wire logic        i_sector_pulse,
    input  wire logic        i_step_pulse,
    input  wire logic        i_zero_mark,
    input  wire logic        i_baud_tick,
    input  wire logic [2:0]  i_phase_sync,
    // Timer outputs
    output logic             o_event_request,
    output logic [1:0]       o_compare_pulse,
    output logic             o_pwm
);

    dual_timer_pkg::state_type s;
    dual_timer_pkg::state_type next_s;

    logic        meas_rise;
    logic        meas_fall;
    logic [15:0] sys_vec;
    logic        pre_tick;
    logic        bus_wr;
    logic        bus_take;
    logic [5:0]  bus_idx;
    logic [1:0]  soft_restart;
    logic [1:0]  cmp_evt;
    logic [1:0]  count_evt;
    logic [1:0]  restart_evt;
    logic [1:0]  capture_evt;
    logic [1:0]  overflow_evt;
    logic [8:0]  pending;
    logic [3:0]  vector_no;

    // Pick one of four sources by a two-bit code
    function automatic logic pick4(input logic [1:0] sel, input logic [3:0] srcs);
        return srcs[sel];
    endfunction

    // Shared preselect code table for all three system signal choices
    function automatic logic pick_sys(input logic [3:0] code, input logic [15:0] vec);
        return vec[code];
    endfunction

    // Byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be);
        merge16 = old;
        if (be[0]) begin
            merge16[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            merge16[15:8] = wdata[15:8];
        end
    endfunction

    // Edge detection reads only the second and third sync stages
    assign meas_rise = s.meas_sync[1] & ~s.meas_sync[2];
    assign meas_fall = ~s.meas_sync[1] & s.meas_sync[2];

    // System signal table: pulses at 0..3, phase rises 8..10, falls 11..13
    assign sys_vec = {2'b00, ~i_phase_sync & s.phase_prev, i_phase_sync & ~s.phase_prev,
                      4'h0, i_baud_tick, i_zero_mark, i_step_pulse, i_sector_pulse};

    // Prescaler tick; setting zero ticks every cycle
    assign pre_tick = (s.pre_cnt == s.pre_val);

    // Bus decode; a write takes effect only in the answer cycle
    assign bus_idx  = i_avs_address[7:2];
    assign bus_take = (s.bus == dual_timer_pkg::BUS_DONE);
    assign bus_wr   = bus_take & i_avs_write;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_take;
    assign o_avs_readdata    = s.rdata;

    // Write-only restart pulses from the control register
    always_comb begin
        soft_restart = 2'b00;
        if (bus_wr && bus_idx == `IDX_TIMER_CONTROL && i_avs_byteenable[0]) begin
            soft_restart = i_avs_writedata[`CTL_RESTART_A_BIT +: 2];
        end
    end

    // Per-unit event selection; compare uses registered values so A and B never loop
    always_comb begin
        cmp_evt      = 2'b00;
        count_evt    = 2'b00;
        restart_evt  = 2'b00;
        capture_evt  = 2'b00;
        overflow_evt = 2'b00;
        for (int u = 0; u < 2; u++) begin
            cmp_evt[u] = s.changed[u] && (s.count[u] == s.match[u])
                         && (s.setup[u][`SETUP_MODE_LSB +: 2] != `MODE_CAPTURE);
        end
        for (int u = 0; u < 2; u++) begin
            count_evt[u] = s.enable[u] & pick4(s.setup[u][`SETUP_CLK_LSB +: 2],
                {pick_sys(s.presel[u][`PRESEL_CLK_LSB +: 4], sys_vec),
                 meas_fall, meas_rise, pre_tick});
            capture_evt[u] = s.enable[u]
                && (s.setup[u][`SETUP_MODE_LSB +: 2] == `MODE_CAPTURE)
                && pick4(s.setup[u][`SETUP_CAPTURE_LSB +: 2],
                   {pick_sys(s.presel[u][`PRESEL_CAPTURE_LSB +: 4], sys_vec),
                    meas_fall, meas_rise, cmp_evt[1 - u]});
            case (s.setup[u][`SETUP_RESTART_LSB +: 3])
                `RST_SRC_ENABLE:    restart_evt[u] = s.enable[u] & ~s.enable_prev[u];
                `RST_SRC_OTHER_CMP: restart_evt[u] = cmp_evt[1 - u];
                `RST_SRC_MEAS_RISE: restart_evt[u] = meas_rise;
                `RST_SRC_MEAS_FALL: restart_evt[u] = meas_fall;
                `RST_SRC_SYSTEM:    restart_evt[u] =
                    pick_sys(s.presel[u][`PRESEL_RESTART_LSB +: 4], sys_vec);
                default:            restart_evt[u] = 1'b0;
            endcase
            // Loop mode restarts on its own match whatever the restart source
            if (s.setup[u][`SETUP_MODE_LSB +: 2] == `MODE_LOOP && cmp_evt[u]) begin
                restart_evt[u] = 1'b1;
            end
            if (soft_restart[u]) begin
                restart_evt[u] = 1'b1;
            end
            overflow_evt[u] = ~restart_evt[u] & count_evt[u]
                              & (s.count[u] == `SIGNED_LIMIT);
        end
    end

    // Lowest pending vector among gated and switched-on flags
    always_comb begin
        pending   = s.flags & s.gate & s.venable;
        vector_no = `VECTOR_NONE;
        for (int v = `FLAG_COUNT - 1; v >= 0; v--) begin
            if (pending[v]) begin
                vector_no = 4'(v);
            end
        end
    end

    // Request only for vectors above the nesting ceiling in priority
    assign o_event_request = (vector_no != `VECTOR_NONE) && (vector_no < s.ceiling);
    assign o_compare_pulse = cmp_evt;
    assign o_pwm           = s.pwm;

    // Next state
    always_comb begin
        next_s = s;

        // Pin synchroniser and phase history
        next_s.meas_sync  = {s.meas_sync[1:0], i_meas};
        next_s.phase_prev = i_phase_sync;

        // Bus answer: one wait cycle, then data and acknowledge
        case (s.bus)
            dual_timer_pkg::BUS_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    next_s.bus   = dual_timer_pkg::BUS_DONE;
                    next_s.rdata = 32'h0000_0000;
                    case (bus_idx)
                        `IDX_CLOCK_DIVIDER:   next_s.rdata[7:0]  = s.pre_val;
                        `IDX_TIMER_CONTROL:   next_s.rdata[1:0]  = s.enable;
                        `IDX_UNIT_A_SETUP:    next_s.rdata[9:0]  = s.setup[0];
                        `IDX_UNIT_B_SETUP:    next_s.rdata[9:0]  = s.setup[1];
                        `IDX_UNIT_A_MATCH:    next_s.rdata[15:0] = s.match[0];
                        `IDX_UNIT_B_MATCH:    next_s.rdata[15:0] = s.match[1];
                        `IDX_UNIT_A_COUNT:    next_s.rdata[15:0] = s.count[0];
                        `IDX_UNIT_B_COUNT:    next_s.rdata[15:0] = s.count[1];
                        `IDX_UNIT_A_SOURCE:   next_s.rdata[11:0] = s.presel[0];
                        `IDX_UNIT_B_SOURCE:   next_s.rdata[11:0] = s.presel[1];
                        `IDX_EVENT_FLAGS:     next_s.rdata[8:0]  = s.flags;
                        `IDX_EVENT_GATE:      next_s.rdata[8:0]  = s.gate;
                        `IDX_NESTING_CEILING: next_s.rdata[3:0]  = s.ceiling;
                        `IDX_PENDING_VECTOR:  next_s.rdata[3:0]  = vector_no;
                        default:              next_s.rdata       = 32'h0000_0000;
                    endcase
                end
            end
            dual_timer_pkg::BUS_DONE: begin
                next_s.bus = dual_timer_pkg::BUS_IDLE;
            end
            default: begin
                next_s.bus = dual_timer_pkg::BUS_IDLE;
            end
        endcase

        // Software writes; counters have no write path
        if (bus_wr) begin
            case (bus_idx)
                `IDX_CLOCK_DIVIDER: begin
                    next_s.pre_val = 8'(merge16({8'h00, s.pre_val}, i_avs_writedata,
                                                i_avs_byteenable));
                end
                `IDX_TIMER_CONTROL: begin
                    if (i_avs_byteenable[0]) begin
                        next_s.enable = i_avs_writedata[`CTL_ENABLE_LSB +: 2];
                    end
                end
                `IDX_UNIT_A_SETUP: begin
                    next_s.setup[0] = 10'(merge16({6'h00, s.setup[0]}, i_avs_writedata,
                                      i_avs_byteenable)) & `SETUP_WRITE_MASK;
                end
                `IDX_UNIT_B_SETUP: begin
                    next_s.setup[1] = 10'(merge16({6'h00, s.setup[1]}, i_avs_writedata,
                                      i_avs_byteenable)) & `SETUP_WRITE_MASK;
                end
                `IDX_UNIT_A_MATCH: begin
                    next_s.match[0] = merge16(s.match[0], i_avs_writedata, i_avs_byteenable);
                end
                `IDX_UNIT_B_MATCH: begin
                    next_s.match[1] = merge16(s.match[1], i_avs_writedata, i_avs_byteenable);
                end
                `IDX_UNIT_A_SOURCE: begin
                    next_s.presel[0] = 12'(merge16({4'h0, s.presel[0]}, i_avs_writedata,
                                       i_avs_byteenable));
                end
                `IDX_UNIT_B_SOURCE: begin
                    next_s.presel[1] = 12'(merge16({4'h0, s.presel[1]}, i_avs_writedata,
                                       i_avs_byteenable));
                end
                `IDX_EVENT_FLAGS: begin
                    // Write one to clear
                    next_s.flags = s.flags & ~9'(merge16(16'h0000, i_avs_writedata,
                                                         i_avs_byteenable));
                end
                `IDX_EVENT_GATE: begin
                    next_s.gate = 9'(merge16({7'h00, s.gate}, i_avs_writedata,
                                             i_avs_byteenable));
                end
                `IDX_VECTOR_SWITCH_ON: begin
                    if (i_avs_byteenable[0] && i_avs_writedata[3:0] < `VECTOR_NONE) begin
                        next_s.venable[i_avs_writedata[3:0]] = 1'b1;
                    end
                end
                `IDX_VECTOR_SWITCH_OFF: begin
                    if (i_avs_byteenable[0] && i_avs_writedata[3:0] < `VECTOR_NONE) begin
                        next_s.venable[i_avs_writedata[3:0]] = 1'b0;
                    end
                end
                `IDX_NESTING_CEILING: begin
                    if (i_avs_byteenable[0]) begin
                        next_s.ceiling = i_avs_writedata[3:0];
                    end
                end
                `IDX_PENDING_VECTOR: begin
                    if (i_avs_byteenable[0] && i_avs_writedata[3:0] < `VECTOR_NONE) begin
                        next_s.flags[i_avs_writedata[3:0]] = 1'b0;
                    end
                end
                default: begin
                    next_s.flags = s.flags;
                end
            endcase
        end

        // Prescaler counts 0..setting then wraps; 8 bits times 16 bits of range
        next_s.pre_cnt = pre_tick ? 8'h00 : s.pre_cnt + 8'h01;
        if (bus_wr && bus_idx == `IDX_TIMER_CONTROL && i_avs_byteenable[0]
                && i_avs_writedata[`CTL_RESTART_P_BIT]) begin
            next_s.pre_cnt = 8'h00;
            next_s.flags[`FLAG_PRESCALE_RESTART] = 1'b1;
        end

        // Counter units; hardware runs after software so its events win
        next_s.enable_prev = s.enable;
        for (int u = 0; u < 2; u++) begin
            next_s.changed[u] = 1'b0;
            if (restart_evt[u]) begin
                next_s.count[u] = `COUNT_ZERO;
                next_s.flags[`FLAG_RESTART_LSB + u] = 1'b1;
            end else if (count_evt[u]) begin
                next_s.count[u]   = s.count[u] + 16'h0001;
                next_s.changed[u] = 1'b1;
            end
            if (overflow_evt[u]) begin
                next_s.flags[`FLAG_OVERFLOW_LSB + u] = 1'b1;
            end
            if (capture_evt[u]) begin
                next_s.match[u] = s.count[u];
                next_s.flags[`FLAG_CAPTURE_LSB + u] = 1'b1;
            end
            if (cmp_evt[u]) begin
                next_s.flags[`FLAG_COMPARE_LSB + u] = 1'b1;
                if (s.setup[u][`SETUP_MODE_LSB +: 2] == `MODE_ONCE) begin
                    next_s.enable[u] = 1'b0;
                end
            end
        end

        // PWM level: high from A restart, low at B match
        if (cmp_evt[1]) begin
            next_s.pwm = 1'b0;
        end else if (restart_evt[0]) begin
            next_s.pwm = 1'b1;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            s         <= '0;
            s.bus     <= dual_timer_pkg::BUS_IDLE;
            s.venable <= `VECTOR_ENABLE_RESET;
            s.ceiling <= `CEILING_RESET;
        end else begin
            s <= next_s;
        end
    end

endmodule // dual_timer_unit

// *** tb_top.sv ***
// Self-checking bench of the dual timer
`timescale 1ns/1ps
module tb_top;
    logic        i_mclk, i_rstn, i_avs_read, i_avs_write, meas, o_event_request, o_pwm;
    logic [7:0]  i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [3:0]  pulse;
    logic [2:0]  phase;
    logic [1:0]  o_compare_pulse;
    logic [15:0] q, v1;
    int          error_cnt, compares, t1, t2;
    int          codes [10] = '{0, 1, 2, 3, 8, 9, 10, 11, 12, 13};
    logic [7:0]  ra [16] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38,
                             8'h40, 8'h48, 8'hC0, 8'hD0, 8'hE0, 8'hF0, 8'hF8, 8'h14};
    trigger_source u_src (.i_mclk(i_mclk), .o_meas(meas), .o_pulse(pulse), .o_phase(phase));
    dual_timer_unit u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_meas(meas), .i_sector_pulse(pulse[0]),
        .i_step_pulse(pulse[1]), .i_zero_mark(pulse[2]), .i_baud_tick(pulse[3]),
        .i_phase_sync(phase), .o_event_request(o_event_request),
        .o_compare_pulse(o_compare_pulse), .o_pwm(o_pwm));
    // 200 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    task automatic stop_test();
        $display("counts: %0d mismatches in %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waitrequest sampled at each rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_avs_address <= a;
        i_avs_writedata <= {16'h0000, d};
        i_avs_write <= w;
        i_avs_read <= !w;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        if (n == 20)
            chk("waitrequest", 16'h0000, 16'h0001);
        q = o_avs_readdata[15:0];
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
        bus(1'b0, a, 16'h0000);
        chk(nm, e, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic chk_req(input logic e, input string nm);
        @(negedge i_mclk);
        chk(nm, 16'(e), 16'(o_event_request));
    endtask
    // Cycles until the next compare pulse of one unit
    task automatic wait_cmp(input int u, output int c);
        c = 0;
        do begin
            @(negedge i_mclk);
            c++;
        end while (o_compare_pulse[u] !== 1'b1 && c < 40000);
        if (c == 40000)
            chk("compare wait", 16'h0000, 16'h0001);
    endtask
    // Overflow run dominates; limit leaves ample margin
    initial begin
        repeat (80000) @(posedge i_mclk);
        error_cnt++;
        stop_test();
    end
    initial begin
        {i_rstn, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
        error_cnt = 0;
        compares = 0;
        repeat (6) @(posedge i_mclk);
        i_rstn <= 1'b1;
        foreach (ra[i]) rd(ra[i], (ra[i] >= 8'hF0) ? 16'h0009 : 16'h0000, "reset");
        wr(8'h00, 16'hFFFF);
        rd(8'h00, 16'h00FF, "divider");
        wr(8'h10, 16'hFFFF);
        rd(8'h10, 16'h037F, "setup A");
        wr(8'h40, 16'hFFFF);
        rd(8'h40, 16'h0FFF, "source A");
        wr(8'h28, 16'hA5C3);
        rd(8'h28, 16'hA5C3, "match B");
        wr(8'h30, 16'h1234);
        rd(8'h30, 16'h0000, "count A");
        wr(8'h10, 16'h0000);
        wr(8'h40, 16'h0000);
        wr(8'h08, 16'h001F);
        rd(8'h08, 16'h0003, "control");
        wr(8'h08, 16'h0000);
        $display("test registers done");
        // Both reads sit 44 cycles apart: 11 ticks at divide by 4
        wr(8'h00, 16'h0003);
        wr(8'h08, 16'h0011);
        bus(1'b0, 8'h30, 16'h0000);
        v1 = q;
        repeat (41) @(posedge i_mclk);
        bus(1'b0, 8'h30, 16'h0000);
        chk("prescaled count", v1 + 16'h000B, q);
        wr(8'h08, 16'h0000);
        $display("test prescaler done");
        wr(8'h00, 16'h0000);
        wr(8'h10, 16'h0200);
        wr(8'h20, 16'h0005);
        wr(8'h28, 16'h0003);
        wr(8'h08, 16'h0003);
        wait_cmp(0, t1);
        wait_cmp(0, t1);
        wait_cmp(0, t2);
        chk("loop period", 16'(t1), 16'(t2));
        chk("loop length", 16'h0006, 16'(t1));
        wr(8'h08, 16'h0000);
        $display("test loop done");
        // B counts rises and snapshots on falls
        wr(8'h18, 16'h0341);
        wr(8'h08, 16'h0002);
        repeat (5) u_src.meas_pulse();
        repeat (6) @(posedge i_mclk);
        rd(8'h28, 16'h0005, "capture B");
        rd(8'h38, 16'h0005, "count B");
        wr(8'h08, 16'h0000);
        $display("test capture done");
        wr(8'h10, 16'h0373);
        wr(8'h40, 16'h0321);
        wr(8'h08, 16'h0005);
        repeat (3) u_src.sys_event(1);
        u_src.sys_event(3);
        u_src.sys_event(2);
        repeat (2) u_src.sys_event(1);
        rd(8'h20, 16'h0003, "system capture");
        rd(8'h30, 16'h0002, "system restart");
        wr(8'h10, 16'h0003);
        foreach (codes[i]) begin
            wr(8'h40, 16'(codes[i]));
            wr(8'h08, 16'h0005);
            repeat (3) u_src.sys_event(codes[i]);
            rd(8'h30, 16'h0003, "system count");
        end
        wr(8'h08, 16'h0000);
        $display("test sources done");
        wr(8'h20, 16'h8000);
        wr(8'h10, 16'h0100);
        wr(8'hC0, 16'h01FF);
        wr(8'h08, 16'h0001);
        wait_cmp(0, t1);
        rd(8'h08, 16'h0000, "once enable");
        rd(8'hC0, 16'h008A, "flags");
        wr(8'hD0, 16'h0080);
        chk_req(1'b1, "request");
        rd(8'hF8, 16'h0007, "pending");
        wr(8'hF8, 16'h0007);
        chk_req(1'b0, "request cleared");
        rd(8'hC0, 16'h000A, "flags left");
        wr(8'h08, 16'h0010);
        rd(8'hC0, 16'h000B, "prescale flag");
        wr(8'hD0, 16'h01FF);
        rd(8'hF8, 16'h0000, "lowest pending");
        chk_req(1'b1, "request all");
        wr(8'hF0, 16'h0000);
        chk_req(1'b0, "request ceiling");
        $display("test events done");
        stop_test();
    end
endmodule // tb_top

// *** trigger_source.sv ***
// Model of the measurement pin and the internal trigger sources
`timescale 1ns/1ps
module trigger_source (
    // Clock
    input  wire logic i_mclk,
    // Trigger lines: pulses are sector, step, zero, baud
    output logic       o_meas,
    output logic [3:0] o_pulse,
    output logic [2:0] o_phase
);
    // Quiet lines at time zero
    initial begin
        o_meas = 1'b0;
        o_pulse = 4'h0;
        o_phase = 3'h0;
    end
    // Levels held long enough for the pin synchroniser
    task automatic meas_pulse();
        @(posedge i_mclk);
        o_meas <= 1'b1;
        repeat (4) @(posedge i_mclk);
        o_meas <= 1'b0;
        repeat (4) @(posedge i_mclk);
    endtask
    // Codes below 4 pulse one cycle, phase codes run a rise and a fall
    task automatic sys_event(input int code);
        @(posedge i_mclk);
        if (code < 4)
            o_pulse[code] <= 1'b1;
        else
            o_phase[(code - 8) % 3] <= 1'b1;
        @(posedge i_mclk);
        o_pulse <= 4'h0;
        o_phase <= 3'h0;
        @(posedge i_mclk);
    endtask
endmodule // trigger_source
